// [bench/axi4_multi_manager_interconnect_tb.sv]
// self-checking bench for the multi-manager interconnect
`timescale 1ns/10ps
`default_nettype none
module axi4_multi_manager_interconnect_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic xclk = 1'b0;
  logic x_en_n = 1'b1;
  int n_errors = 0;
  int n_tests = 0;
  logic [1:0] rsp;
  logic [31:0] rdv;
  logic [31:0] aw_q [2];
  logic [31:0] wd_q [2];
  wire [1:0] m_awvalid, m_awready, m_wvalid, m_wready, m_wlast, m_bvalid, m_bready, m_arvalid, m_arready;
  wire [1:0] m_rvalid, m_rready, m_rlast, m_awid, m_arid, m_bid, m_rid, m_awuser, m_wuser, m_aruser, m_buser;
  wire [1:0] m_ruser, s_awvalid, s_wvalid, s_wlast, s_bready, s_arvalid, s_rready, s_awuser, s_wuser, s_aruser;
  wire [1:0] s_rlast;
  wire [3:0] m_bresp, m_rresp, s_awid, s_arid;
  wire [5:0] m_awsize, m_arsize, s_awsize, s_arsize;
  wire [7:0] m_wstrb, s_wstrb;
  wire [15:0] m_awlen, m_arlen, s_awlen, s_arlen;
  wire [63:0] m_awaddr, m_araddr, m_wdata, m_rdata, s_awaddr, s_araddr, s_wdata;
  logic [1:0] s_awready = '0, s_wready = '0, s_bvalid = '0, s_arready = '0, s_rvalid = '0, s_buser = '0, s_ruser = '0;
  logic [3:0] s_bid = '0, s_bresp = '0, s_rid = '0, s_rresp = '0;
  logic [63:0] s_rdata = '0;
  always #12.5 core_clk = ~core_clk;
  always #17 xclk = ~xclk;
  assign m_araddr = m_awaddr;
  assign m_arid = m_awid;
  assign m_wuser = m_awuser;
  assign m_aruser = m_awuser;
  assign m_wlast = m_wvalid;
  assign m_wstrb = {{4{m_wvalid[1]}}, {4{m_wvalid[0]}}};
  assign m_awlen = 16'h0000;
  assign m_arlen = 16'h0000;
  assign m_awsize = 6'h12;
  assign m_arsize = 6'h12;
  assign s_rlast = s_rvalid;
  axi4_multi_manager_interconnect #(.NM(2), .NS(2), .SIDW(2), .M_CDC(2'b10)) uut (
    .core_clk, .core_clk_en(1'b1), .rst_n, .port1_crossing_clock_in(xclk),
    .port1_crossing_clock_enable_n(x_en_n), .port1_crossing_reset_n(rst_n),
    .m_awvalid, .m_awready, .m_awaddr, .m_awlen, .m_awsize, .m_awid, .m_awuser, .m_wvalid, .m_wready,
    .m_wdata, .m_wstrb, .m_wlast, .m_wuser, .m_bvalid, .m_bready, .m_bid, .m_bresp, .m_buser, .m_arvalid,
    .m_arready, .m_araddr, .m_arlen, .m_arsize, .m_arid, .m_aruser, .m_rvalid, .m_rready, .m_rdata, .m_rresp,
    .m_rlast, .m_rid, .m_ruser, .s_awvalid, .s_awready, .s_awaddr, .s_awlen, .s_awsize, .s_awid, .s_awuser,
    .s_wvalid, .s_wready, .s_wdata, .s_wstrb, .s_wlast, .s_wuser, .s_bvalid, .s_bready, .s_bid, .s_bresp,
    .s_buser, .s_arvalid, .s_arready, .s_araddr, .s_arlen, .s_arsize, .s_arid, .s_aruser, .s_rvalid,
    .s_rready, .s_rdata, .s_rresp, .s_rlast, .s_rid, .s_ruser);
  for (genvar i = 0; i < 2; i++) begin : g_mgr
    mgr_model m (.clk(core_clk), .awready(m_awready[i]), .wready(m_wready[i]), .bvalid(m_bvalid[i]),
      .arready(m_arready[i]), .rvalid(m_rvalid[i]), .bresp(m_bresp[2*i +: 2]), .rresp(m_rresp[2*i +: 2]),
      .rdata(m_rdata[32*i +: 32]), .awvalid(m_awvalid[i]), .wvalid(m_wvalid[i]), .bready(m_bready[i]),
      .arvalid(m_arvalid[i]), .rready(m_rready[i]), .id(m_awid[i]), .user(m_awuser[i]),
      .addr(m_awaddr[32*i +: 32]), .wdata(m_wdata[32*i +: 32]));
  end
  //----
  // subordinates: ready one cycle after valid, single-beat answers
  //----
  always @(posedge core_clk) begin
    for (int k = 0; k < 2; k++) begin
      s_awready[k] <= s_awvalid[k] & ~s_awready[k];
      s_wready[k] <= s_wvalid[k] & ~s_wready[k];
      s_arready[k] <= s_arvalid[k] & ~s_arready[k];
      if (s_awvalid[k] & s_awready[k]) begin
        aw_q[k] <= s_awaddr[32*k +: 32];
        s_bid[2*k +: 2] <= s_awid[2*k +: 2];
        s_buser[k] <= s_awuser[k];
      end
      if (s_wvalid[k] & s_wready[k]) begin
        wd_q[k] <= s_wdata[32*k +: 32];
        s_bvalid[k] <= s_wlast[k];
        s_bresp[2*k +: 2] <= 2'(k);
      end else if (s_bready[k]) begin
        s_bvalid[k] <= 1'b0;
      end
      if (s_arvalid[k] & s_arready[k]) begin
        s_rvalid[k] <= 1'b1;
        s_rid[2*k +: 2] <= s_arid[2*k +: 2];
        s_ruser[k] <= s_aruser[k];
        s_rresp[2*k +: 2] <= 2'(k);
        s_rdata[32*k +: 32] <= s_araddr[32*k +: 32] ^ 32'h0000_00a5;
      end else begin
        if (s_rready[k]) s_rvalid[k] <= 1'b0;
        if (!s_rvalid[k] || s_rready[k]) s_rdata[32*k +: 32] <= ~s_rdata[32*k +: 32];
      end
    end
  end
  //----
  // checks and scenarios
  //----
  task automatic chk_data(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_code(input string what, input logic [1:0] exp, input logic [1:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d, mismatched %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic guard;
    if (g_mgr[0].m.to || g_mgr[1].m.to) begin
      n_errors++;
      $display("mismatch handshake wait expected done seen timeout");
      wrap_up;
    end
  endtask
  task automatic op(input int m, input logic w, input logic [31:0] a, input logic [31:0] d, input logic i);
    if (m == 0 && w) g_mgr[0].m.wr(a, d, i, ~i);
    if (m == 0 && !w) g_mgr[0].m.rd(a, i);
    if (m == 1 && w) g_mgr[1].m.wr(a, d, i, ~i);
    if (m == 1 && !w) g_mgr[1].m.rd(a, i);
    rsp = m ? g_mgr[1].m.cr : g_mgr[0].m.cr;
    rdv = m ? g_mgr[1].m.cd : g_mgr[0].m.cd;
    guard;
  endtask
  task automatic t_write;
    logic [31:0] a;
    logic [31:0] d;
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 2; k++) begin
        a = {k[0], 25'h0, 2'(m), 4'h0};
        d = 32'h5a00_0000 + 32'(m * 256 + k);
        op(m, 1'b1, a, d, k[0]);
        chk_data("aw addr", a, aw_q[k]);
        chk_data("w data", d, wd_q[k]);
        chk_code("sub id", {m[0], k[0]}, s_bid[2*k +: 2]);
        chk_code("bresp", 2'(k), rsp);
        chk_code("aw user", {1'b0, ~k[0]}, {1'b0, s_buser[k]});
        chk_code("b id user", {k[0], ~k[0]}, {m_bid[m], m_buser[m]});
        chk_data("aw len size strb", {8'h00, 5'h0, 3'h2, 4'h0, 4'hf, 7'h0, 1'b1},
          {s_awlen[8*k +: 8], 5'h0, s_awsize[3*k +: 3], 4'h0, s_wstrb[4*k +: 4], 7'h0, s_wlast[k]});
      end
    end
    $display("test write routing done");
  endtask
  task automatic t_read;
    logic [31:0] a;
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 2; k++) begin
        a = {k[0], 23'h0, 2'(m), 2'(k), 4'h8};
        op(m, 1'b0, a, 32'h0, k[0]);
        chk_data("r data", a ^ 32'h0000_00a5, rdv);
        chk_code("rresp", 2'(k), rsp);
        chk_code("r id last", {k[0], 1'b1}, {m_rid[m], m_rlast[m]});
      end
    end
    $display("test read routing done");
  endtask
  task automatic t_decerr;
    logic [31:0] p;
    logic [31:0] q;
    for (int m = 0; m < 2; m++) begin
      p = wd_q[0];
      q = wd_q[1];
      op(m, 1'b0, 32'h4000_0020, 32'h0, 1'b0);
      chk_code("unmapped rresp", fabric_pkg::RESP_DECERR, rsp);
      op(m, 1'b1, 32'h1000_0040, 32'h0bad_c0de, 1'b1);
      chk_code("unmapped bresp", fabric_pkg::RESP_DECERR, rsp);
      chk_data("not forwarded", p, wd_q[0]);
      chk_data("not forwarded 1", q, wd_q[1]);
    end
    $display("test decode error done");
  endtask
  task automatic t_contend;
    fork
      g_mgr[0].m.wr(32'h0000_0200, 32'h0c0c_0000, 1'b0, 1'b1);
      g_mgr[1].m.wr(32'h8000_0204, 32'h0c0c_0001, 1'b1, 1'b0);
    join
    guard;
    chk_code("bresp m0", fabric_pkg::RESP_OKAY, g_mgr[0].m.cr);
    chk_code("bresp m1", 2'h1, g_mgr[1].m.cr);
    chk_data("sub0 data", 32'h0c0c_0000, wd_q[0]);
    chk_data("sub1 data", 32'h0c0c_0001, wd_q[1]);
    $display("test contention done");
  endtask
  task automatic t_gate;
    int seen;
    seen = 0;
    x_en_n = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    fork
      g_mgr[1].m.rd(32'h0000_0104, 1'b0);
      begin
        repeat (8) begin
          @(posedge core_clk);
          seen += int'(m_arready[1]);
        end
        #1;
        x_en_n = 1'b0;
      end
    join
    guard;
    chk_code("gated arready", 2'h0, 2'(seen));
    chk_data("gated r data", 32'h0000_01a1, g_mgr[1].m.cd);
    $display("test crossing gate done");
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    x_en_n = 1'b0;
    t_write;
    t_read;
    t_decerr;
    t_contend;
    t_gate;
    wrap_up;
  end
endmodule
`default_nettype wire

// [bench/fabric_asserts.sv]
// concurrent checks on the interconnect ports
`timescale 1ns/10ps
`default_nettype none
module fabric_asserts #(
  parameter int NM = 2,
  parameter int NS = 2,
  parameter int AW = 32,
  parameter int MIDW = 1,
  parameter int SIDW = 2
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [NM-1:0] m_awvalid,
  input wire logic [NM-1:0] m_awready,
  input wire logic [NM-1:0] m_wready,
  input wire logic [NM-1:0] m_arvalid,
  input wire logic [NM-1:0] m_arready,
  input wire logic [NM-1:0] m_bvalid,
  input wire logic [NM-1:0] m_rvalid,
  input wire logic [NM*AW-1:0] m_araddr,
  input wire logic [NM*2-1:0] m_rresp,
  input wire logic [NS-1:0] s_awvalid,
  input wire logic [NS-1:0] s_awready,
  input wire logic [NS-1:0] s_arvalid,
  input wire logic [NS-1:0] s_bvalid,
  input wire logic [NS-1:0] s_bready,
  input wire logic [NS-1:0] s_rvalid,
  input wire logic [NS-1:0] s_rready,
  input wire logic [NS*AW-1:0] s_awaddr,
  input wire logic [NS*SIDW-1:0] s_bid,
  input wire logic [NS*SIDW-1:0] s_rid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence aw_hs;
    |(m_awvalid & m_awready);
  endsequence
  sequence ar_hs;
    |(m_arvalid & m_arready);
  endsequence
  AST_RESET_QUIET: assert property ($rose(rst_n) |-> {m_awready, m_arready, m_bvalid, m_rvalid, s_awvalid} == '0)
    else $error("outputs not idle after reset");
  AST_AWREADY_PULSE: assert property (|m_awready |=> m_awready == '0)
    else $error("awready longer than one cycle");
  AST_ONE_FWD: assert property ($onehot0({s_awvalid, s_arvalid}))
    else $error("two requests forwarded at once");
  AST_AW_ROUTE0: assert property (s_awvalid[0] |-> s_awaddr[AW-1 -: 4] == 4'h0)
    else $error("wrong subordinate 0 address");
  AST_AW_ROUTE1: assert property (s_awvalid[1] |-> s_awaddr[2*AW-1 -: 4] == 4'h8)
    else $error("wrong subordinate 1 address");
  AST_AW_HOLD: assert property (s_awvalid[0] && !s_awready[0] |=> s_awvalid[0] && $stable(s_awaddr[AW-1:0]))
    else $error("forwarded address dropped early");
  AST_AW_FWD: assert property (aw_hs |=> (|s_awvalid) || (|m_wready))
    else $error("write address not forwarded");
  AST_AR_FWD: assert property (ar_hs |=> (|s_arvalid) || (|m_rvalid))
    else $error("read address not forwarded");
  AST_B_ROUTE: assert property (s_bvalid[0] && s_bready[0] |=> m_bvalid == NM'(1) << $past(s_bid[MIDW]))
    else $error("write response to wrong manager");
  AST_R_ROUTE: assert property (s_rvalid[0] && s_rready[0] |=> m_rvalid == NM'(1) << $past(s_rid[MIDW]))
    else $error("read data to wrong manager");
  AST_DECERR: assert property (m_arvalid[0] && m_arready[0] && m_araddr[AW-1 -: 4] == 4'h4 |=>
    m_rvalid[0] && m_rresp[1:0] == fabric_pkg::RESP_DECERR) else $error("unmapped read not refused");
endmodule
bind axi4_multi_manager_interconnect fabric_asserts #(.NM(NM), .NS(NS), .AW(AW), .MIDW(MIDW), .SIDW(SIDW)) chk (
  .core_clk, .rst_n, .m_awvalid, .m_awready, .m_wready, .m_arvalid, .m_arready, .m_bvalid, .m_rvalid,
  .m_araddr, .m_rresp, .s_awvalid, .s_awready, .s_arvalid, .s_bvalid, .s_bready, .s_rvalid, .s_rready,
  .s_awaddr, .s_bid, .s_rid);
`default_nettype wire

// [bench/mgr_model.sv]
// behavioural axi4 manager driving one manager port of the interconnect
`timescale 1ns/10ps
`default_nettype none
module mgr_model (
  input wire logic clk,
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic [1:0] bresp,
  input wire logic [1:0] rresp,
  input wire logic [31:0] rdata,
  output logic awvalid,
  output logic wvalid,
  output logic bready,
  output logic arvalid,
  output logic rready,
  output logic id,
  output logic user,
  output logic [31:0] addr,
  output logic [31:0] wdata
);
  logic to;
  logic [1:0] cr;
  logic [31:0] cd;
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, id, user, to} = '0;
    addr = '0;
    wdata = '0;
  end
  //----
  // handshakes
  //----
  // bounded wait; answer taken at the edge that shows ready or valid
  task automatic wt(input int k);
    int n;
    logic [4:0] rdy;
    n = 0;
    do begin
      @(posedge clk);
      rdy = {rvalid, arready, bvalid, wready, awready};
      n++;
    end while (!rdy[k] && n < 64);
    cr = (k == 2) ? bresp : rresp;
    cd = rdata;
    if (!rdy[k]) to = 1'b1;
    #1;
  endtask
  // released lines show the inverse of the last value
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic i, input logic u);
    addr = a;
    id = i;
    user = u;
    wdata = ~d;
    awvalid = 1'b1;
    wt(0);
    awvalid = 1'b0;
    addr = ~a;
    wdata = d;
    wvalid = 1'b1;
    wt(1);
    wvalid = 1'b0;
    wdata = ~d;
    bready = 1'b1;
    wt(2);
    bready = 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic i);
    addr = a;
    id = i;
    arvalid = 1'b1;
    wt(3);
    arvalid = 1'b0;
    addr = ~a;
    rready = 1'b1;
    wt(4);
    rready = 1'b0;
  endtask
endmodule
`default_nettype wire

// [rtl/axi4_multi_manager_interconnect.sv]
// shared-path axi4 / axi4-lite interconnect, managers to subordinates
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module axi4_multi_manager_interconnect #(
  parameter int NM = fabric_pkg::DEF_NUM,
  parameter int NS = fabric_pkg::DEF_NUM,
  parameter int AW = fabric_pkg::DEF_ADDR_W,
  parameter int DW = fabric_pkg::DEF_DATA_W,
  parameter int UW = fabric_pkg::DEF_USER_W,
  parameter int MIDW = fabric_pkg::DEF_MGR_ID_W,
  parameter int SIDW = fabric_pkg::DEF_MGR_ID_W + $clog2(fabric_pkg::DEF_NUM),
  parameter int MAX_IDS = fabric_pkg::DEF_MAX_IDS,
  parameter int M_IDS [NM] = '{default: fabric_pkg::DEF_MAX_IDS},
  parameter int M_ADDR_W [NM] = '{default: fabric_pkg::DEF_ADDR_W},
  parameter int S_DATA_W [NS] = '{default: fabric_pkg::DEF_DATA_W},
  parameter logic [AW-1:0] S_BASE [NS] = '{32'h0000_0000, 32'h8000_0000},
  parameter logic [AW-1:0] S_MASK [NS] = '{32'hf000_0000, 32'hf000_0000},
  parameter logic [NM-1:0] M_LITE = '0,
  parameter logic [NS-1:0] S_LITE = '0,
  parameter logic [NM-1:0] M_CDC = '0
) (
  input wire logic core_clk,
  input wire logic core_clk_en,
  input wire logic rst_n,
  input wire logic port1_crossing_clock_in,
  input wire logic port1_crossing_clock_enable_n,
  input wire logic port1_crossing_reset_n,
  input wire logic [NM-1:0] m_awvalid,
  output logic [NM-1:0] m_awready,
  input wire logic [NM*AW-1:0] m_awaddr,
  input wire logic [NM*8-1:0] m_awlen,
  input wire logic [NM*3-1:0] m_awsize,
  input wire logic [NM*MIDW-1:0] m_awid,
  input wire logic [NM*UW-1:0] m_awuser,
  input wire logic [NM-1:0] m_wvalid,
  output logic [NM-1:0] m_wready,
  input wire logic [NM*DW-1:0] m_wdata,
  input wire logic [NM*DW/8-1:0] m_wstrb,
  input wire logic [NM-1:0] m_wlast,
  input wire logic [NM*UW-1:0] m_wuser,
  output logic [NM-1:0] m_bvalid,
  input wire logic [NM-1:0] m_bready,
  output logic [NM*MIDW-1:0] m_bid,
  output logic [NM*2-1:0] m_bresp,
  output logic [NM*UW-1:0] m_buser,
  input wire logic [NM-1:0] m_arvalid,
  output logic [NM-1:0] m_arready,
  input wire logic [NM*AW-1:0] m_araddr,
  input wire logic [NM*8-1:0] m_arlen,
  input wire logic [NM*3-1:0] m_arsize,
  input wire logic [NM*MIDW-1:0] m_arid,
  input wire logic [NM*UW-1:0] m_aruser,
  output logic [NM-1:0] m_rvalid,
  input wire logic [NM-1:0] m_rready,
  output logic [NM*DW-1:0] m_rdata,
  output logic [NM*2-1:0] m_rresp,
  output logic [NM-1:0] m_rlast,
  output logic [NM*MIDW-1:0] m_rid,
  output logic [NM*UW-1:0] m_ruser,
  output logic [NS-1:0] s_awvalid,
  input wire logic [NS-1:0] s_awready,
  output logic [NS*AW-1:0] s_awaddr,
  output logic [NS*8-1:0] s_awlen,
  output logic [NS*3-1:0] s_awsize,
  output logic [NS*SIDW-1:0] s_awid,
  output logic [NS*UW-1:0] s_awuser,
  output logic [NS-1:0] s_wvalid,
  input wire logic [NS-1:0] s_wready,
  output logic [NS*DW-1:0] s_wdata,
  output logic [NS*DW/8-1:0] s_wstrb,
  output logic [NS-1:0] s_wlast,
  output logic [NS*UW-1:0] s_wuser,
  input wire logic [NS-1:0] s_bvalid,
  output logic [NS-1:0] s_bready,
  input wire logic [NS*SIDW-1:0] s_bid,
  input wire logic [NS*2-1:0] s_bresp,
  input wire logic [NS*UW-1:0] s_buser,
  output logic [NS-1:0] s_arvalid,
  input wire logic [NS-1:0] s_arready,
  output logic [NS*AW-1:0] s_araddr,
  output logic [NS*8-1:0] s_arlen,
  output logic [NS*3-1:0] s_arsize,
  output logic [NS*SIDW-1:0] s_arid,
  output logic [NS*UW-1:0] s_aruser,
  input wire logic [NS-1:0] s_rvalid,
  output logic [NS-1:0] s_rready,
  input wire logic [NS*DW-1:0] s_rdata,
  input wire logic [NS*2-1:0] s_rresp,
  input wire logic [NS-1:0] s_rlast,
  input wire logic [NS*SIDW-1:0] s_rid,
  input wire logic [NS*UW-1:0] s_ruser
);
  localparam int GW = $clog2(NM);
  localparam int SW = $clog2(NS);
  localparam int DBL = $clog2(DW / 8);
  localparam logic [2:0] FULL_SIZE = 3'(DBL);

  typedef struct packed {
    fabric_pkg::fabric_state_type st;
    logic [GW-1:0] grant;
    logic [GW-1:0] rr;
    logic [GW-1:0] rsp_mgr;
    logic is_wr;
    logic err;
    logic [SW-1:0] sub;
    logic [AW-1:0] addr;
    logic [7:0] len;
    logic [7:0] cnt;
    logic [2:0] size;
    logic [MIDW-1:0] id;
    logic [UW-1:0] user;
    logic [NM-1:0] awready;
    logic [NM-1:0] arready;
    logic [NM-1:0] wready;
    logic [NM-1:0] bvalid;
    logic [NM-1:0] rvalid;
    logic [DW-1:0] rsp_data;
    logic [1:0] rsp_resp;
    logic rsp_last;
    logic [MIDW-1:0] rsp_id;
    logic [UW-1:0] rsp_user;
    logic [NS-1:0] s_awv;
    logic [NS-1:0] s_arv;
    logic [NS-1:0] s_wv;
    logic [NS-1:0] s_br;
    logic [NS-1:0] s_rr;
    logic [SIDW-1:0] s_id;
    logic [UW-1:0] s_user;
    logic [DW-1:0] w_data;
    logic [DW/8-1:0] w_strb;
    logic w_last;
    logic [UW-1:0] w_user;
  } fabric_regs_type;

  fabric_regs_type r;
  fabric_regs_type n;
  logic [2:0] rst_sync;
  logic [2:0] en_sync;
  logic [2:0] clk_sync;
  logic port1_alive;
  logic next_port1_alive;
  logic [NM-1:0] ok;
  logic [NM-1:0] req;

  // byte offset of the narrow lane within the wide bus
  function automatic int lane_off(input logic [AW-1:0] a, input int s);
    int b;
    b = int'(a[DBL-1:0]);
    return (b & ~(S_DATA_W[s] / 8 - 1)) % (DW / 8);
  endfunction

  function automatic logic [GW-1:0] pick(input logic [NM-1:0] q, input logic [GW-1:0] start);
    logic [GW-1:0] p;
    p = start;
    for (int k = NM - 1; k >= 0; k--) begin
      if (q[(int'(start) + k) % NM]) begin
        p = GW'((int'(start) + k) % NM);
      end
    end
    return p;
  endfunction

  //------------------------------------------------------------
  // crossing port status, sampled into the core clock
  //------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rst_sync <= {3{fabric_pkg::SYNC_RESET_VALUE}};
      en_sync <= {3{fabric_pkg::SYNC_ENABLE_N_RESET_VALUE}};
      clk_sync <= '0;
      port1_alive <= 1'b0;
    end else if (core_clk_en) begin
      rst_sync <= {rst_sync[1:0], port1_crossing_reset_n};
      en_sync <= {en_sync[1:0], port1_crossing_clock_enable_n};
      clk_sync <= {clk_sync[1:0], port1_crossing_clock_in};
      port1_alive <= next_port1_alive;
    end
  end

  always_comb begin
    // crossing port counts as live after one edge of its own clock
    next_port1_alive = rst_sync[1] & (port1_alive | (clk_sync[1] ^ clk_sync[2]));
    ok = '1;
    if (NM > 1 && M_CDC[1 % NM]) begin
      ok[1 % NM] = port1_alive & rst_sync[1] & ~en_sync[1];
    end
    req = (m_awvalid | m_arvalid) & ok;
  end

  //------------------------------------------------------------
  // transaction sequencer
  //------------------------------------------------------------
  always_comb begin
    logic [GW-1:0] g;
    logic [GW-1:0] mg;
    logic [SW-1:0] s;
    logic hit;
    logic wr;
    logic [AW-1:0] a;
    int off;
    g = r.grant;
    s = r.sub;
    mg = '0;
    hit = 1'b0;
    wr = 1'b0;
    a = '0;
    off = 0;
    n = r;
    case (r.st)
      fabric_pkg::st_idle: begin
        if (|req) begin
          g = pick(req, r.rr);
          wr = m_awvalid[g] & ok[g];
          n.grant = g;
          n.is_wr = wr;
          n.awready[g] = wr;
          n.arready[g] = ~wr;
          n.st = fabric_pkg::st_accept;
        end
      end
      fabric_pkg::st_accept: begin
        n.awready = '0;
        n.arready = '0;
        a = r.is_wr ? m_awaddr[g*AW +: AW] : m_araddr[g*AW +: AW];
        a = a & AW'((64'h1 << M_ADDR_W[g]) - 64'h1);
        n.addr = a;
        n.len = r.is_wr ? m_awlen[g*8 +: 8] : m_arlen[g*8 +: 8];
        n.size = r.is_wr ? m_awsize[g*3 +: 3] : m_arsize[g*3 +: 3];
        n.id = r.is_wr ? m_awid[g*MIDW +: MIDW] : m_arid[g*MIDW +: MIDW];
        n.user = r.is_wr ? m_awuser[g*UW +: UW] : m_aruser[g*UW +: UW];
        if (M_LITE[g]) begin
          n.len = fabric_pkg::LEN_SINGLE;
          n.size = FULL_SIZE;
          n.id = '0;
        end
        for (int k = NS - 1; k >= 0; k--) begin
          if ((a & S_MASK[k]) == S_BASE[k]) begin
            hit = 1'b1;
            s = SW'(k);
          end
        end
        n.sub = s;
        n.cnt = '0;
        n.rsp_mgr = g;
        n.err = ~hit | (S_LITE[s] & (n.len != fabric_pkg::LEN_SINGLE)) |
                (int'(n.id) >= ((M_IDS[g] < MAX_IDS) ? M_IDS[g] : MAX_IDS));
        n.s_id = SIDW'({g, n.id});
        n.s_user = S_LITE[s] ? '0 : n.user;
        if (n.err) begin
          n.rsp_resp = fabric_pkg::RESP_DECERR;
          n.rsp_data = '0;
          n.rsp_id = n.id;
          n.rsp_user = '0;
          n.rsp_last = (n.len == fabric_pkg::LEN_SINGLE);
          n.wready[g] = r.is_wr;
          n.rvalid[g] = ~r.is_wr;
          n.st = r.is_wr ? fabric_pkg::st_err : fabric_pkg::st_resp_put;
        end else begin
          n.s_awv[s] = r.is_wr;
          n.s_arv[s] = ~r.is_wr;
          n.st = fabric_pkg::st_sub_addr;
        end
      end
      fabric_pkg::st_sub_addr: begin
        if ((r.s_awv[s] & s_awready[s]) | (r.s_arv[s] & s_arready[s])) begin
          n.s_awv = '0;
          n.s_arv = '0;
          n.wready[g] = r.is_wr;
          n.s_rr[s] = ~r.is_wr;
          n.st = r.is_wr ? fabric_pkg::st_w_get : fabric_pkg::st_resp_get;
        end
      end
      fabric_pkg::st_w_get: begin
        if (m_wvalid[g]) begin
          off = lane_off(r.addr, int'(s));
          n.wready[g] = 1'b0;
          n.w_data = m_wdata[g*DW +: DW] >> (off * 8);
          n.w_strb = m_wstrb[g*DW/8 +: DW/8] >> off;
          n.w_last = M_LITE[g] | m_wlast[g*1];
          n.w_user = S_LITE[s] ? '0 : m_wuser[g*UW +: UW];
          n.s_wv[s] = 1'b1;
          n.st = fabric_pkg::st_w_put;
        end
      end
      fabric_pkg::st_w_put: begin
        if (s_wready[s]) begin
          n.s_wv = '0;
          n.addr = r.addr + (AW'(1) << r.size);
          n.wready[g] = ~r.w_last;
          n.s_br[s] = r.w_last;
          n.st = r.w_last ? fabric_pkg::st_resp_get : fabric_pkg::st_w_get;
        end
      end
      fabric_pkg::st_resp_get: begin
        if (r.is_wr ? s_bvalid[s] : s_rvalid[s]) begin
          mg = r.is_wr ? s_bid[s*SIDW+MIDW +: GW] : s_rid[s*SIDW+MIDW +: GW];
          off = lane_off(r.addr, int'(s));
          n.s_br = '0;
          n.s_rr = '0;
          n.rsp_mgr = mg;
          n.rsp_id = r.is_wr ? s_bid[s*SIDW +: MIDW] : s_rid[s*SIDW +: MIDW];
          n.rsp_resp = r.is_wr ? s_bresp[s*2 +: 2] : s_rresp[s*2 +: 2];
          n.rsp_user = S_LITE[s] ? '0 : (r.is_wr ? s_buser[s*UW +: UW] : s_ruser[s*UW +: UW]);
          n.rsp_data = s_rdata[s*DW +: DW] << (off * 8);
          n.rsp_last = S_LITE[s] | s_rlast[s];
          n.bvalid[mg] = r.is_wr;
          n.rvalid[mg] = ~r.is_wr;
          n.st = fabric_pkg::st_resp_put;
        end
      end
      fabric_pkg::st_resp_put: begin
        if (r.is_wr ? m_bready[r.rsp_mgr] : m_rready[r.rsp_mgr]) begin
          n.bvalid = '0;
          n.rvalid = '0;
          n.cnt = r.cnt + fabric_pkg::LEN_STEP;
          n.addr = r.addr + (AW'(1) << r.size);
          if (r.is_wr | r.rsp_last) begin
            n.rr = GW'((int'(r.grant) + 1) % NM);
            n.st = fabric_pkg::st_idle;
          end else if (r.err) begin
            n.rsp_last = (n.cnt == r.len);
            n.rvalid[r.rsp_mgr] = 1'b1;
          end else begin
            n.s_rr[s] = 1'b1;
            n.st = fabric_pkg::st_resp_get;
          end
        end
      end
      fabric_pkg::st_err: begin
        // drain write beats of a refused burst (unmapped, burst to a lite subordinate, or id out of range)
        if (m_wvalid[g] & (M_LITE[g] | m_wlast[g*1])) begin
          n.wready = '0;
          n.bvalid[g] = 1'b1;
          n.st = fabric_pkg::st_resp_put;
        end
      end
      default: begin
        n.st = fabric_pkg::st_idle;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      r <= '0;
    end else if (core_clk_en) begin
      r <= n;
    end
  end

  //------------------------------------------------------------
  // port wiring, all from registers
  //------------------------------------------------------------
  assign m_awready = r.awready;
  assign m_arready = r.arready;
  assign m_wready = r.wready;
  assign m_bvalid = r.bvalid;
  assign m_rvalid = r.rvalid;
  assign m_bid = {NM{r.rsp_id}};
  assign m_bresp = {NM{r.rsp_resp}};
  assign m_buser = {NM{r.rsp_user}};
  assign m_rdata = {NM{r.rsp_data}};
  assign m_rresp = {NM{r.rsp_resp}};
  assign m_rlast = {NM{r.rsp_last}};
  assign m_rid = {NM{r.rsp_id}};
  assign m_ruser = {NM{r.rsp_user}};
  assign s_awvalid = r.s_awv;
  assign s_arvalid = r.s_arv;
  assign s_wvalid = r.s_wv;
  assign s_bready = r.s_br;
  assign s_rready = r.s_rr;
  assign s_awaddr = {NS{r.addr}};
  assign s_araddr = {NS{r.addr}};
  assign s_awlen = {NS{r.len}};
  assign s_arlen = {NS{r.len}};
  assign s_awsize = {NS{r.size}};
  assign s_arsize = {NS{r.size}};
  assign s_awid = {NS{r.s_id}};
  assign s_arid = {NS{r.s_id}};
  assign s_awuser = {NS{r.s_user}};
  assign s_aruser = {NS{r.s_user}};
  assign s_wdata = {NS{r.w_data}};
  assign s_wstrb = {NS{r.w_strb}};
  assign s_wlast = {NS{r.w_last}};
  assign s_wuser = {NS{r.w_user}};
endmodule
`default_nettype wire

// [rtl/fabric_pkg.sv]
// shared constants and types for the multi-manager interconnect
package fabric_pkg;
  localparam int DEF_ADDR_W = 32;
  localparam int DEF_DATA_W = 32;
  localparam int DEF_USER_W = 1;
  localparam int DEF_MGR_ID_W = 1;
  localparam int DEF_MAX_IDS = 16;
  localparam int DEF_NUM = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [7:0] LEN_SINGLE = 8'h00;
  localparam logic [7:0] LEN_STEP = 8'h01;
  localparam logic SYNC_RESET_VALUE = 1'b0;
  localparam logic SYNC_ENABLE_N_RESET_VALUE = 1'b1;

  // gray order along the usual write path
  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_accept = 3'h1,
    st_sub_addr = 3'h3,
    st_w_get = 3'h2,
    st_w_put = 3'h6,
    st_resp_get = 3'h7,
    st_resp_put = 3'h5,
    st_err = 3'h4
  } fabric_state_type;
endpackage
